/* File: verilog/pulse_gen_lines.sv */
/*
 * three pulse generators driving three general-purpose front lines, with line function select.
 * assumes configuration and status signals are synchronous to clk, except the front-line
 * inputs and extended digital lines, which are synchronised here.
 */
`timescale 1ns/1ps
module pulse_gen_lines
    import pulse_gen_pkg::*;
#(
    parameter int unsigned LINES = NUM_LINES,
    parameter int unsigned XIO_W = 8
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    // tick rate
    input  wire logic [DIV_WIDTH-1:0]     tick_div,
    output logic      [DIV_WIDTH-1:0]     tick_div_rd,
    // card state
    input  wire logic                     card_trigger,
    input  wire logic                     card_armed,
    input  wire logic                     card_running,
    input  wire logic                     card_marker,
    input  wire logic                     sys_clk_phase,
    input  wire logic [XIO_W-1:0]         extended_digital_lines,
    input  wire logic [XIO_W-1:0]         xio_mask,
    // generator setup
    input  pg_cfg_type                    pg_cfg [LINES],
    input  wire logic [LINES-1:0]         sw_trigger,
    // line setup
    input  line_fn_type                   line_fn [LINES],
    input  wire logic [LINES-1:0]         line_is_output,
    input  wire logic [LINES-1:0]         async_out_val,
    input  wire logic [LINES-1:0]         sync_out_val,
    // front lines
    input  wire logic [LINES-1:0]         line_in,
    output logic      [LINES-1:0]         line_out,
    output logic      [LINES-1:0]         line_oe,
    output logic      [LINES-1:0]         line_in_rd,
    output logic      [LINES-1:0]         pg_busy
);

    typedef struct packed {
        logic [LINES-1:0]      in_s1;
        logic [LINES-1:0]      in_s2;
        logic [XIO_W-1:0]      xio_s1;
        logic [XIO_W-1:0]      xio_s2;
        logic [DIV_WIDTH-1:0]  div_cnt;
        logic                  tick;
        logic [DIV_WIDTH-1:0]  div_rd;
        logic [LINES-1:0]      out;
        logic [LINES-1:0]      oe;
        logic [LINES-1:0]      busy;
    } top_state_type;

    top_state_type            s_r;
    top_state_type            s_nxt;
    // kept apart from s_r: it is cleared by the raw reset and never frozen by clk_en
    logic [1:0]               rst_sync_r;
    pg_gen_type               g_r   [LINES];
    pg_gen_type               g_nxt [LINES];
    logic                     rst_n_int;
    logic [LINES-1:0]         trig;
    logic [LINES-1:0]         gate_ok;

    assign rst_n_int = rst_sync_r[1];

    // trigger source decode, used per generator
    function automatic logic trig_of(input pg_cfg_type c, input logic sw, input logic [LINES-1:0] outs,
                                     input logic card, input logic xio_hit);
        logic r;
        r = 1'b0;
        unique case (c.trg_src)
            trg_software:  r = sw;
            trg_card:      r = card;
            trg_other_gen: r = outs[c.other_sel];
            trg_extended:  r = xio_hit;
        endcase
        return r;
    endfunction : trig_of

    function automatic logic gate_of(input gate_type gt, input logic armed, input logic running);
        logic r;
        r = 1'b1;
        unique case (gt)
            gate_none:    r = 1'b1;
            gate_armed:   r = armed;
            gate_running: r = running;
            default:      r = 1'b0;
        endcase
        return r;
    endfunction : gate_of

    always_comb begin
        s_nxt = s_r;
        s_nxt.in_s1 = line_in;
        s_nxt.in_s2 = s_r.in_s1;
        s_nxt.xio_s1 = extended_digital_lines;
        s_nxt.xio_s2 = s_r.xio_s1;
        // tick divider; div 0 is treated as 1 so the tick never stops
        s_nxt.tick = 1'b0;
        if (s_r.div_cnt + DIV_WIDTH'(1) >= tick_div || tick_div == '0) begin
            s_nxt.div_cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + DIV_WIDTH'(1);
        end
        s_nxt.div_rd = (tick_div == '0) ? DIV_DEFAULT : tick_div;
        for (int i = 0; i < LINES; i++) begin
            s_nxt.oe[i] = line_is_output[i];
            s_nxt.busy[i] = (g_r[i].state != st_idle);
            unique case (line_fn[i])
                fn_async_out: s_nxt.out[i] = async_out_val[i];
                fn_sync_out:  s_nxt.out[i] = sync_out_val[i];
                fn_trigger:   s_nxt.out[i] = card_trigger;
                fn_run:       s_nxt.out[i] = card_running;
                fn_arm:       s_nxt.out[i] = card_armed;
                fn_marker:    s_nxt.out[i] = card_marker;
                fn_sysclk:    s_nxt.out[i] = sys_clk_phase;
                fn_pulse:     s_nxt.out[i] = g_r[i].out;
            endcase
        end
    end

    generate
        for (genvar i = 0; i < LINES; i++) begin : gen_pg
            assign trig[i] = trig_of(pg_cfg[i], sw_trigger[i], s_r.out, card_trigger,
                                     |(s_r.xio_s2 & xio_mask));
            assign gate_ok[i] = gate_of(pg_cfg[i].gate, card_armed, card_running);

            always_comb begin
                g_nxt[i] = g_r[i];
                if (!gate_ok[i]) begin
                    g_nxt[i].state = st_idle;
                    g_nxt[i].out = 1'b0;
                end else if (s_r.tick) begin
                    unique case (g_r[i].state)
                        st_idle: begin
                            g_nxt[i].out = 1'b0;
                            // gated mode runs while the gate holds, without a trigger
                            if (trig[i] || pg_cfg[i].mode == pg_gated) begin
                                g_nxt[i].cnt = pg_cfg[i].delay;
                                g_nxt[i].left = (pg_cfg[i].mode == pg_single) ? 32'h0000_0001 : pg_cfg[i].loops;
                                g_nxt[i].state = (pg_cfg[i].delay == '0) ? st_run : st_delay;
                                if (pg_cfg[i].delay == '0) begin
                                    g_nxt[i].cnt = '0;
                                end
                            end
                        end
                        st_delay: begin
                            g_nxt[i].cnt = g_r[i].cnt - SET_WIDTH'(1);
                            if (g_r[i].cnt <= SET_WIDTH'(1)) begin
                                g_nxt[i].cnt = '0;
                                g_nxt[i].state = st_run;
                            end
                        end
                        st_run: begin
                            // period below the minimum is held at the minimum
                            g_nxt[i].out = (g_r[i].cnt < ((pg_cfg[i].width < MIN_WIDTH) ? MIN_WIDTH
                                            : pg_cfg[i].width));
                            g_nxt[i].cnt = g_r[i].cnt + SET_WIDTH'(1);
                            if (g_r[i].cnt + SET_WIDTH'(1) >= ((pg_cfg[i].period < MIN_PERIOD) ? MIN_PERIOD
                                                               : pg_cfg[i].period)) begin
                                g_nxt[i].cnt = '0;
                                if (g_r[i].left != LOOP_FOREVER) begin
                                    g_nxt[i].left = g_r[i].left - SET_WIDTH'(1);
                                    if (g_r[i].left == SET_WIDTH'(1)) begin
                                        g_nxt[i].state = st_idle;
                                    end
                                end
                            end
                        end
                        default: g_nxt[i].state = st_idle;
                    endcase
                end
            end

            always_ff @(posedge clk or negedge rst_n_int) begin
                if (!rst_n_int) begin
                    g_r[i] <= '{state: st_idle, cnt: '0, left: '0, out: 1'b0};
                end else if (clk_en) begin
                    g_r[i] <= g_nxt[i];
                end
            end
        end
    endgenerate

    // reset release is synchronised; the rest of the state resets from that copy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            s_r.in_s1 <= '0;
            s_r.in_s2 <= '0;
            s_r.xio_s1 <= '0;
            s_r.xio_s2 <= '0;
            s_r.div_cnt <= '0;
            s_r.tick <= 1'b0;
            s_r.div_rd <= DIV_DEFAULT;
            s_r.out <= '0;
            s_r.oe <= '0;
            s_r.busy <= '0;
        end else if (clk_en) begin
            s_r.in_s1 <= s_nxt.in_s1;
            s_r.in_s2 <= s_nxt.in_s2;
            s_r.xio_s1 <= s_nxt.xio_s1;
            s_r.xio_s2 <= s_nxt.xio_s2;
            s_r.div_cnt <= s_nxt.div_cnt;
            s_r.tick <= s_nxt.tick;
            s_r.div_rd <= s_nxt.div_rd;
            s_r.out <= s_nxt.out;
            s_r.oe <= s_nxt.oe;
            s_r.busy <= s_nxt.busy;
        end
    end

    assign tick_div_rd = s_r.div_rd;
    assign line_out    = s_r.out;
    assign line_oe     = s_r.oe;
    assign line_in_rd  = s_r.in_s2;
    assign pg_busy     = s_r.busy;

endmodule : pulse_gen_lines

/* File: verilog/pulse_gen_pkg.sv */
/*
 * shared types and constants of the three-line pulse generator block.
 * assumes one 50 mhz clock and software-set configuration held outside on plain ports.
 */
package pulse_gen_pkg;

    localparam int unsigned NUM_LINES     = 3;
    localparam int unsigned SET_WIDTH     = 32;
    localparam int unsigned DIV_WIDTH     = 16;
    localparam logic [31:0] MIN_PERIOD    = 32'h0000_0002;
    localparam logic [31:0] MIN_WIDTH     = 32'h0000_0001;
    localparam logic [31:0] LOOP_FOREVER  = 32'h0000_0000;
    localparam logic [15:0] DIV_DEFAULT   = 16'h0001;
    localparam real         TICK_NS_MIN   = 6.4;
    localparam real         CLK_NS        = 20.0;
    // generator tick period may not go below 6.4 ns; at 50 mhz it never reaches the ceiling
    localparam int unsigned TICK_MIN_CYC  = (TICK_NS_MIN <= CLK_NS) ? 1 : 2;

    typedef enum logic [1:0] {
        pg_single,
        pg_repeat,
        pg_gated
    } pg_mode_type;

    typedef enum logic [1:0] {
        trg_software,
        trg_card,
        trg_other_gen,
        trg_extended
    } trg_src_type;

    typedef enum logic [1:0] {
        gate_none,
        gate_armed,
        gate_running
    } gate_type;

    typedef enum logic [2:0] {
        fn_async_out,
        fn_sync_out,
        fn_trigger,
        fn_run,
        fn_arm,
        fn_marker,
        fn_sysclk,
        fn_pulse
    } line_fn_type;

    typedef struct packed {
        pg_mode_type           mode;
        trg_src_type           trg_src;
        logic [1:0]            other_sel;
        gate_type              gate;
        logic [SET_WIDTH-1:0]  period;
        logic [SET_WIDTH-1:0]  width;
        logic [SET_WIDTH-1:0]  delay;
        logic [SET_WIDTH-1:0]  loops;
    } pg_cfg_type;

    typedef enum logic [1:0] {
        st_idle,
        st_delay,
        st_run
    } pg_state_type;

    typedef struct packed {
        pg_state_type          state;
        logic [SET_WIDTH-1:0]  cnt;
        logic [SET_WIDTH-1:0]  left;
        logic                  out;
    } pg_gen_type;

endpackage : pulse_gen_pkg

/* File: tb/pulse_gen_lines_props.sv */
/* checker of pulse_gen_lines: line drive, enable, readback and generator 0 timing.
   assumes the bench keeps line 0 on fn_pulse and clk_en high while pulses run. */
`timescale 1ns/1ps
module pulse_gen_lines_props
    import pulse_gen_pkg::*;
#(parameter int unsigned LINES = NUM_LINES, parameter int unsigned XIO_W = 8) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // setup and card state
    input wire logic [DIV_WIDTH-1:0] tick_div,
    input wire logic card_armed,
    input wire logic card_running,
    input pg_cfg_type pg_cfg [LINES],
    input line_fn_type line_fn [LINES],
    input wire logic [LINES-1:0] line_is_output,
    input wire logic [LINES-1:0] sync_out_val,
    // observed
    input wire logic [DIV_WIDTH-1:0] tick_div_rd,
    input wire logic [LINES-1:0] line_in,
    input wire logic [LINES-1:0] line_out,
    input wire logic [LINES-1:0] line_oe,
    input wire logic [LINES-1:0] line_in_rd,
    input wire logic [LINES-1:0] pg_busy
);
    // settle counter hides the two-flop reset release
    logic [2:0] up_r;
    logic [31:0] hi_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_r <= 3'h0;
            hi_r <= 32'h0;
        end else begin
            up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
            hi_r <= line_out[0] ? hi_r + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    div_readback_a: assert property (up_r == 3'h7 && clk_en && $past(clk_en) && $stable(tick_div)
        |-> tick_div_rd == ((tick_div == 16'h0) ? 16'h1 : tick_div)) else $error("divider readback wrong");
    oe_follow_a: assert property (up_r == 3'h7 && $past(clk_en)
        |-> line_oe == $past(line_is_output)) else $error("line enable wrong");
    input_sync_a: assert property ((clk_en && $stable(line_in))[*5] ##0 up_r == 3'h7
        |-> line_in_rd == line_in) else $error("input readback wrong");
    idle_low_a: assert property (up_r == 3'h7 && line_fn[0] == fn_pulse && !pg_busy[0] && !$past(pg_busy[0])
        |-> !line_out[0]) else $error("idle line high");
    high_width_a: assert property ($fell(line_out[0]) && pg_busy[0] && tick_div_rd == 16'h1
        && line_fn[0] == fn_pulse |-> hi_r == pg_cfg[0].width) else $error("pulse width wrong");
    gate_armed_a: assert property (up_r == 3'h7 && $past(clk_en) && $past(clk_en, 2) && !$past(card_armed)
        && !$past(card_armed, 2) && $past(pg_cfg[0].gate) == gate_armed && $past(pg_cfg[0].gate, 2) == gate_armed
        |-> !pg_busy[0]) else $error("generator ran gated off");
    sync_out_a: assert property (up_r == 3'h7 && $past(clk_en) && $past(line_fn[1]) == fn_sync_out
        && $past(line_is_output[1]) |-> line_out[1] == $past(sync_out_val[1])) else $error("sync out wrong");
    run_state_a: assert property (up_r == 3'h7 && $past(clk_en) && $past(line_fn[1]) == fn_run
        && $past(line_is_output[1]) |-> line_out[1] == $past(card_running)) else $error("run state wrong");
endmodule : pulse_gen_lines_props
bind pulse_gen_lines pulse_gen_lines_props #(.LINES(LINES), .XIO_W(XIO_W)) props_u (.*);

/* File: tb/line_partner.sv */
/* far-side equipment on the three front lines.
   assumes the bench names the released lines it drives; others float to the pull-up. */
`timescale 1ns/1ps
module line_partner
    import pulse_gen_pkg::*;
(
    // from the design
    input wire logic [NUM_LINES-1:0] line_out,
    input wire logic [NUM_LINES-1:0] line_oe,
    // bench control
    input wire logic [NUM_LINES-1:0] drive_en,
    input wire logic [NUM_LINES-1:0] drive_val,
    // to the design
    output logic [NUM_LINES-1:0] line_in
);
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            line_in[i] = line_oe[i] ? line_out[i] : (drive_en[i] ? drive_val[i] : 1'h1);
        end
    end
endmodule : line_partner

/* File: tb/pulse_gen_lines_tb.sv */
/* bench of pulse_gen_lines: a queue model of generator 0 and of the line mux.
   assumes line_partner on the lines; inputs change on the falling edge. */
`timescale 1ns/1ps
module pulse_gen_lines_tb
    import pulse_gen_pkg::*;
;
    `define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; $display("ERROR t=%0t %h %h", $time, a, e); end end
    logic clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, card_trigger = 1'h0, card_armed = 1'h0, card_running = 1'h0;
    logic card_marker = 1'h0, sys_clk_phase = 1'h0;
    logic [15:0] tick_div = 16'h1, tick_div_rd;
    logic [7:0] extended_digital_lines = 8'h0, xio_mask = 8'hff;
    pg_cfg_type pg_cfg [3];
    line_fn_type line_fn [3];
    logic [2:0] sw_trigger = 3'h0, line_is_output = 3'h3, async_out_val = 3'h0, sync_out_val = 3'h0, drv_v = 3'h0;
    logic [2:0] line_in, line_out, line_oe, line_in_rd, pg_busy;
    int num_errors = 0, checked = 0;
    logic [31:0] seed = 32'h1b37;
    bit exp_q[$];
    always #10 clk = ~clk;
    pulse_gen_lines dut_u (.*);
    line_partner far_u (.line_out(line_out), .line_oe(line_oe), .drive_en(~line_is_output), .drive_val(drv_v),
        .line_in(line_in));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic summarize();
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (pg_busy[0] !== v && k < 40) begin
            @(negedge clk);
            k++;
        end
        `CHK(pg_busy[0], v)
    endtask : wait_busy
    // endless runs are cut after three periods by turning the gate false
    task automatic pulse_run(input pg_mode_type m, input trg_src_type src, input logic [31:0] per, wid, dly, lps);
        bit endless;
        endless = (m != pg_single) && (lps == 32'h0);
        pg_cfg[0] = '{m, src, 2'h1, (m == pg_gated) ? gate_running : gate_none, per, wid, dly, lps};
        exp_q = {};
        repeat (1 + dly) exp_q.push_back(1'h0);
        for (int i = 0; i < per * ((m == pg_single) ? 1 : (endless ? 3 : lps)); i++) exp_q.push_back(i % per < wid);
        if (!endless) repeat (3) exp_q.push_back(1'h0);
        repeat (3) @(negedge clk);
        `CHK(pg_busy[0], 1'h0)
        if (m == pg_gated) card_running = 1'h1;
        else if (src == trg_card) card_trigger = 1'h1;
        else sw_trigger[0] = 1'h1;
        @(negedge clk);
        sw_trigger[0] = 1'h0;
        card_trigger = 1'h0;
        foreach (exp_q[i]) begin
            @(negedge clk);
            `CHK(line_out[0], exp_q[i])
        end
        pg_cfg[0].gate = gate_armed;
        card_running = 1'h0;
        repeat (3) @(negedge clk);
        `CHK({line_out[0], pg_busy[0]}, 2'h0)
    endtask : pulse_run
    task automatic fn_check(input line_fn_type f);
        logic e;
        logic [31:0] r;
        line_fn[1] = f;
        r = rnd();
        {async_out_val, sync_out_val, card_armed, card_marker, sys_clk_phase, card_running, card_trigger, drv_v} = r[13:0];
        repeat (6) @(negedge clk);
        case (f)
            fn_async_out: e = async_out_val[1];
            fn_sync_out: e = sync_out_val[1];
            fn_run: e = card_running;
            fn_arm: e = card_armed;
            fn_marker: e = card_marker;
            fn_trigger: e = card_trigger;
            default: e = sys_clk_phase;
        endcase
        `CHK(line_out[1], e)
        `CHK(line_in_rd[2], drv_v[2])
        `CHK(line_oe, line_is_output)
    endtask : fn_check
    initial begin
        logic [31:0] per;
        pg_cfg = '{default: '0};
        line_fn = '{fn_pulse, fn_sync_out, fn_async_out};
        repeat (8) @(negedge clk);
        reset_n = 1'h1;
        repeat (4) @(negedge clk);
        pulse_run(pg_repeat, trg_software, 32'h4, 32'h2, 32'h0, 32'h1);
        pulse_run(pg_single, trg_card, 32'h2, 32'h1, 32'h0, 32'h3);
        pulse_run(pg_repeat, trg_software, 32'h3, 32'h1, 32'h2, 32'h0);
        // gated run with endless loops; a finished loop count would restart after an idle tick
        pulse_run(pg_gated, trg_software, 32'h5, 32'h3, 32'h0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            per = 32'h2 + rnd() % 6;
            pulse_run(pg_mode_type'(i % 2), trg_software, per, 32'h1 + rnd() % (per - 1), rnd() % 4, 32'h1 + rnd() % 3);
        end
        for (int f = 0; f < 7; f++) fn_check(line_fn_type'(f));
        line_fn[1] = fn_sync_out;
        pg_cfg[0] = '{pg_single, trg_other_gen, 2'h1, gate_none, 32'h4, 32'h2, 32'h0, 32'h1};
        sync_out_val[1] = 1'h1;
        wait_busy(1'h1);
        sync_out_val[1] = 1'h0;
        wait_busy(1'h0);
        pg_cfg[0].trg_src = trg_extended;
        extended_digital_lines = 8'h1;
        wait_busy(1'h1);
        for (int d = 0; d < 4; d++) begin
            tick_div = 16'(d);
            repeat (3) @(negedge clk);
            `CHK(tick_div_rd, (d == 0) ? 16'h1 : 16'(d))
        end
        // a frozen block must not pick up the new divider
        clk_en = 1'h0;
        tick_div = 16'h7;
        repeat (3) @(negedge clk);
        `CHK(tick_div_rd, 16'h3)
        clk_en = 1'h1;
        reset_n = 1'h0;
        @(negedge clk);
        `CHK({line_out, pg_busy}, 6'h0)
        summarize();
    end
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule : pulse_gen_lines_tb
